// ### hw/sync_serial_port.v
// Synchronous serial port: master/slave, three frame formats, 8x16 FIFOs.
// Assumes software-side ports are synchronous to clk_sys; pins are async.
`timescale 1ns/1ps
`include "ssp_defs.vh"
module sync_serial_port
(
   input  wire        clk_sys,
   input  wire        rst,
   input  wire        port_enable,
   input  wire        slave_mode,
   input  wire [1:0]  frame_format,
   input  wire [3:0]  data_size_m1,
   input  wire        clock_polarity_bit,
   input  wire        clock_phase_bit,
   input  wire [7:0]  prescale_divisor,
   input  wire [7:0]  clock_rate_field,
   input  wire [3:0]  interrupt_mask_register,
   input  wire [1:0]  dma_control_register,
   input  wire        tx_wr,
   input  wire [15:0] tx_wdata,
   input  wire        rx_rd,
   output reg  [15:0] rx_rdata,
   output wire        tx_full,
   output wire        rx_empty,
   input  wire        overrun_clear,
   input  wire        timeout_clear,
   output wire [3:0]  raw_interrupt_status,
   output wire [3:0]  masked_interrupt_status,
   output wire        irq,
   output wire        dma_tx_req,
   output wire        dma_rx_req,
   output reg         serial_bit_clock_o,
   output reg         serial_bit_clock_oe,
   input  wire        serial_bit_clock_i,
   output reg         frame_select_line_o,
   output reg         frame_select_line_oe,
   input  wire        frame_select_line_i,
   output reg         serial_transmit_line,
   output reg         serial_transmit_oe,
   input  wire        serial_receive_line
);
   localparam ST_IDLE = 2'h0;
   localparam ST_LEAD = 2'h1;
   localparam ST_BITS = 2'h2;
   localparam ST_TAIL = 2'h3;

   // Ring store doubles as history, so an empty slave replays old words
   reg  [15:0] tx_mem [0:7];
   reg  [15:0] rx_mem [0:7];
   reg  [2:0]  tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
   reg  [3:0]  tx_cnt_q, rx_cnt_q;
   reg  [7:0]  hist_q;
   reg  [1:0]  st_q;
   reg  [15:0] pre_cnt_q;
   reg         tick;
   reg         phase_q;
   reg  [4:0]  bit_q;
   reg  [15:0] tx_sh_q, rx_sh_q;
   reg  [4:0]  len_q;
   reg         ovr_q, tmo_q;
   reg  [31:0] idle_cnt_q;
   reg  [2:0]  sck_s, fss_s, rxd_s;
   reg         sck_q, fss_q, rxd_q;
   reg         push_rx;
   reg  [15:0] push_val;
   wire        tx_empty = (tx_cnt_q == 4'h0);
   wire        rx_full  = (rx_cnt_q == `FIFO_DEPTH);
   wire        do_pop   = rx_rd & ~rx_empty;
   wire        do_wr    = tx_wr & ~tx_full;
   wire        master   = port_enable & ~slave_mode;
   wire        spi_like = (frame_format != `FMT_PULSE);
   wire        idle_lvl = (frame_format == `FMT_SPI) ? clock_polarity_bit
                                                       : 1'b0;
   wire [4:0]  word_len = {1'b0, data_size_m1} + 5'h01;
   reg         tx_pop;
   reg  [2:0]  tx_src;

   assign tx_full  = (tx_cnt_q == `FIFO_DEPTH);
   assign rx_empty = (rx_cnt_q == 4'h0);

   always @(posedge clk_sys)
      if (do_wr)
         tx_mem[tx_wp_q] <= tx_wdata;
   always @(posedge clk_sys)
      if (rst)
      begin
         tx_wp_q  <= 3'h0;
         tx_rp_q  <= 3'h0;
         tx_cnt_q <= 4'h0;
         hist_q   <= 8'h00;
      end
      else
      begin
         if (do_wr)
         begin
            tx_wp_q <= tx_wp_q + 3'h1;
            hist_q[tx_wp_q] <= 1'b1;
         end
         if (tx_pop & ~tx_empty)
            tx_rp_q <= tx_rp_q + 3'h1;
         tx_cnt_q <= tx_cnt_q + {3'h0, do_wr} - {3'h0, tx_pop & ~tx_empty};
      end

   always @*
   begin
      tx_src = tx_empty ? tx_wp_q : tx_rp_q;
   end
   wire [15:0] tx_word = (tx_empty & ~hist_q[tx_src]) ? 16'h0000
                                                         : tx_mem[tx_src];

   always @(posedge clk_sys)
      if (push_rx & ~rx_full)
         rx_mem[rx_wp_q] <= push_val;
   always @(posedge clk_sys)
      if (rst)
      begin
         rx_wp_q  <= 3'h0;
         rx_rp_q  <= 3'h0;
         rx_cnt_q <= 4'h0;
         rx_rdata <= 16'h0000;
         ovr_q    <= 1'b0;
      end
      else
      begin
         if (push_rx & ~rx_full)
            rx_wp_q <= rx_wp_q + 3'h1;
         if (do_pop)
         begin
            rx_rp_q  <= rx_rp_q + 3'h1;
            rx_rdata <= rx_mem[rx_rp_q];
         end
         rx_cnt_q <= rx_cnt_q + {3'h0, push_rx & ~rx_full} - {3'h0, do_pop};
         // Set wins over clear
         if (push_rx & rx_full)
            ovr_q <= 1'b1;
         else if (overrun_clear)
            ovr_q <= 1'b0;
      end

   // Three-stage pin sampling; change accepted when stages 2 and 3 agree
   always @(posedge clk_sys)
      if (rst)
      begin
         sck_s <= 3'h0;
         fss_s <= 3'h7;
         rxd_s <= 3'h0;
         sck_q <= 1'b0;
         fss_q <= 1'b1;
         rxd_q <= 1'b0;
      end
      else
      begin
         sck_s <= {sck_s[1:0], serial_bit_clock_i};
         fss_s <= {fss_s[1:0], frame_select_line_i};
         rxd_s <= {rxd_s[1:0], serial_receive_line};
         if (sck_s[1] == sck_s[2])
            sck_q <= sck_s[2];
         if (fss_s[1] == fss_s[2])
            fss_q <= fss_s[2];
         if (rxd_s[1] == rxd_s[2])
            rxd_q <= rxd_s[2];
      end

   // half-bit tick
   // Half period is prescale*(1+rate)/2 cycles; prescale assumed even
   wire [15:0] half_div = ({8'h00, prescale_divisor} *
                           ({8'h00, clock_rate_field} + 16'h0001)) >> 1;
   always @(posedge clk_sys)
      if (rst | (st_q == ST_IDLE))
      begin
         pre_cnt_q <= 16'h0000;
         tick      <= 1'b0;
      end
      else if (pre_cnt_q + 16'h0001 >= half_div)
      begin
         pre_cnt_q <= 16'h0000;
         tick      <= 1'b1;
      end
      else
      begin
         pre_cnt_q <= pre_cnt_q + 16'h0001;
         tick      <= 1'b0;
      end

   reg  sck_prev_q;
   wire sck_rise = sck_q & ~sck_prev_q;
   wire sck_fall = ~sck_q & sck_prev_q;
   always @(posedge clk_sys)
      if (rst)
         sck_prev_q <= 1'b0;
      else
         sck_prev_q <= sck_q;

   // Sample and launch edges for slave side; phase, polarity
   wire s_first = clock_polarity_bit ? sck_fall : sck_rise;
   wire s_secnd = clock_polarity_bit ? sck_rise : sck_fall;
   wire s_cap   = (frame_format == `FMT_PULSE) ? sck_fall :
                  (clock_phase_bit ? s_secnd : s_first);
   wire s_lnch  = (frame_format == `FMT_PULSE) ? sck_rise :
                  (clock_phase_bit ? s_first : s_secnd);

   // Transfer engine
   always @(posedge clk_sys)
      if (rst)
      begin
         st_q <= ST_IDLE;
         phase_q <= 1'b0;
         bit_q <= 5'h00;
         tx_sh_q <= 16'h0000;
         rx_sh_q <= 16'h0000;
         len_q <= 5'h00;
         tx_pop <= 1'b0;
         push_rx <= 1'b0;
         push_val <= 16'h0000;
         serial_bit_clock_o <= 1'b0;
         frame_select_line_o <= 1'b1;
         serial_transmit_line <= 1'b0;
      end
      else
      begin
         tx_pop  <= 1'b0;
         push_rx <= 1'b0;
         if (!port_enable)
         begin
            st_q <= ST_IDLE;
            serial_bit_clock_o <= idle_lvl;
            frame_select_line_o <= spi_like;
         end
         else if (master)
            case (st_q)
               ST_IDLE:
               begin
                  serial_bit_clock_o <= idle_lvl;
                  frame_select_line_o <= spi_like;
                  if (!tx_empty)
                  begin
                     // message takes the low eight bits
                     tx_sh_q <= (frame_format == `FMT_HALF) ?
                                tx_word << 5'h08 :
                                tx_word << (5'h10 - word_len);
                     tx_pop  <= 1'b1;
                     len_q   <= (frame_format == `FMT_HALF) ? `CTRL_MSG_BITS
                                                            : word_len;
                     bit_q   <= 5'h00;
                     phase_q <= 1'b0;
                     st_q    <= ST_LEAD;
                     // select low; pulse format raises it later
                     frame_select_line_o <= 1'b0;
                  end
               end
               ST_LEAD:
                  if (tick)
                  begin
                     phase_q <= ~phase_q;
                     if (phase_q)
                     begin
                        st_q <= ST_BITS;
                        // MSB first; pulse format waits a rise
                        if (spi_like)
                           serial_transmit_line <= tx_sh_q[15];
                     end
                     // pulse starts with the clock rise
                     else if (!spi_like)
                        frame_select_line_o <= 1'b1;
                     if (!spi_like)
                        serial_bit_clock_o <= ~serial_bit_clock_o;
                  end
               ST_BITS:
                  if (tick)
                  begin
                     phase_q <= ~phase_q;
                     serial_bit_clock_o <= ~serial_bit_clock_o;
                     // Capture samples just before its own edge, so data
                     // launched half a period earlier has cleared the pins
                     if (phase_q != ((frame_format == `FMT_PULSE) ? 1'b1 :
                                     clock_phase_bit))
                     begin
                        // Launch edge
                        if (bit_q != 5'h00)
                        begin
                           tx_sh_q <= tx_sh_q << 1;
                           serial_transmit_line <= tx_sh_q[14];
                        end
                        // pulse ends, MSB on the first rise
                        else if (!spi_like)
                        begin
                           frame_select_line_o <= 1'b0;
                           serial_transmit_line <= tx_sh_q[15];
                        end
                     end
                     else
                     begin
                        rx_sh_q <= {rx_sh_q[14:0], rxd_q};
                        bit_q   <= bit_q + 5'h01;
                        if (bit_q + 5'h01 == len_q)
                        begin
                           if (frame_format == `FMT_HALF &&
                               len_q == `CTRL_MSG_BITS &&
                               word_len != `CTRL_MSG_BITS)
                           begin
                              len_q <= word_len;
                              bit_q <= 5'h00;
                           end
                           else
                              st_q <= ST_TAIL;
                        end
                     end
                  end
               default:
                  if (tick)
                  begin
                     // Clock returns to idle before select is released
                     serial_bit_clock_o <= idle_lvl;
                     if (serial_bit_clock_o == idle_lvl)
                     begin
                        frame_select_line_o <= spi_like;
                        push_rx  <= 1'b1;
                        push_val <= rx_sh_q &
                                    ((16'h0001 << word_len) - 16'h0001);
                        st_q     <= ST_IDLE;
                     end
                  end
            endcase
         else
         begin
            // Slave: follow external clock and select
            if ((spi_like & fss_q) | (~spi_like & fss_q & (st_q == ST_IDLE)))
            begin
               bit_q <= 5'h00;
               st_q  <= ST_BITS;
               tx_sh_q <= tx_word << (5'h10 - word_len);
               tx_pop  <= spi_like ? 1'b0 : 1'b1;
               serial_transmit_line <= tx_word[data_size_m1];
            end
            if (spi_like & ~fss_q & (st_q == ST_IDLE))
               st_q <= ST_BITS;
            if (s_cap)
            begin
               rx_sh_q <= {rx_sh_q[14:0], rxd_q};
               bit_q   <= bit_q + 5'h01;
               if (bit_q + 5'h01 == word_len)
               begin
                  push_rx  <= 1'b1;
                  push_val <= {rx_sh_q[14:0], rxd_q} &
                              ((16'h0001 << word_len) - 16'h0001);
                  bit_q    <= 5'h00;
                  tx_pop   <= 1'b1;
                  tx_sh_q  <= tx_word << (5'h10 - word_len);
               end
            end
            if (s_lnch)
            begin
               serial_transmit_line <= tx_sh_q[15];
               if (bit_q != 5'h00)
                  tx_sh_q <= tx_sh_q << 1;
            end
         end
      end

   always @*
   begin
      serial_bit_clock_oe  = master;
      frame_select_line_oe = master;
      serial_transmit_oe   = port_enable & (st_q != ST_IDLE) &
                             (spi_like | master | ~fss_q);
   end

   always @(posedge clk_sys)
      if (rst)
      begin
         idle_cnt_q <= 32'h00000000;
         tmo_q      <= 1'b0;
      end
      else
      begin
         if ((st_q != ST_IDLE) | rx_empty | sck_rise | sck_fall)
            idle_cnt_q <= 32'h00000000;
         else if (idle_cnt_q != `TIMEOUT_CYC)
            idle_cnt_q <= idle_cnt_q + 32'h00000001;
         if (!rx_empty && idle_cnt_q + 32'h00000001 == `TIMEOUT_CYC)
            tmo_q <= 1'b1;
         else if (timeout_clear)
            tmo_q <= 1'b0;
      end

   // sources: tx service, rx service, time-out, overrun
   assign raw_interrupt_status = {ovr_q, tmo_q,
                                  rx_cnt_q >= `RX_LEVEL_HIGH,
                                  tx_cnt_q <= `TX_LEVEL_LOW};
   assign masked_interrupt_status = raw_interrupt_status &
                                    interrupt_mask_register;
   assign irq = |masked_interrupt_status;
   assign dma_tx_req = dma_control_register[1] & ~tx_full;
   assign dma_rx_req = dma_control_register[0] & ~rx_empty;
endmodule // sync_serial_port

// ### hw/ssp_defs.vh
// Constants for the synchronous serial port: formats, sizes, timing.
// Assumes inclusion by the port module only; definitions only.
//
// Contract
// - Prescale divides system clock by even 2..254
// - Further divide by one plus rate field
// - Transmit store sixteen bits, eight entries deep
// - Empty slave sends eighth older word, else zero
// - Received words registered into eight-entry store
// - DMA requests for both stores, empty request
// - Four interrupt sources ORed into one line
// - Mask one passes a source, zero blocks
// - Raw and masked status both readable
// - Frame length four to sixteen, MSB first
// - Time-out when clock idle and data held
// - SPI and half-duplex select active low
// - Frame pulse one period; drive rise, latch fall
// - Half-duplex eight-bit message, then slave reply
// - Pulse format idle: clock, select low, data off
// - Pulse format: select pulse, load, MSB next
// - Pulse format: shift on rise, latch on fall
// - Polarity bit sets SPI clock idle level
// - Phase bit picks first or second capture edge
`ifndef SSP_DEFS_VH
`define SSP_DEFS_VH
`define FMT_SPI         2'h0
`define FMT_PULSE       2'h1
`define FMT_HALF        2'h2
`define FIFO_DEPTH      8
`define FIFO_AW         3
`define DATA_W          16
`define CTRL_MSG_BITS   5'h08
`define PRESCALE_MIN    8'h02
`define TIMEOUT_BITS    32
`define SYS_CLK_HZ      10000000
`define TIMEOUT_NS      3200
`define TIMEOUT_CYC     ((`TIMEOUT_NS * (`SYS_CLK_HZ / 1000000) + 999) / 1000)
`define TX_LEVEL_LOW    4'h4
`define RX_LEVEL_HIGH   4'h4
`endif

// ### tb/sync_serial_port_props.sv
// Port checker: status, DMA requests, serial clock framing.
// Assumes bind onto sync_serial_port; framing checks are SPI master only.
`timescale 1ns/1ps
module sync_serial_port_props
(
   input wire        clk_sys, rst, port_enable, slave_mode, rx_rd,
   input wire        clock_polarity_bit, overrun_clear, timeout_clear,
   input wire        tx_full, rx_empty, irq, dma_tx_req, dma_rx_req,
   input wire        serial_bit_clock_o, frame_select_line_o,
   input wire [1:0]  frame_format, dma_control_register,
   input wire [3:0]  data_size_m1, interrupt_mask_register,
   input wire [3:0]  raw_interrupt_status, masked_interrupt_status,
   input wire [15:0] rx_rdata
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   wire       spi_m = port_enable && !slave_mode && frame_format == 2'h0;
   reg        sck_q;
   reg  [7:0] edges_q;
   reg  [5:0] idle_q;
   wire       tick = sck_q != serial_bit_clock_o;
   // Idle count allows the pin synchronisers some slack
   always @(posedge clk_sys)
   begin
      sck_q <= serial_bit_clock_o;
      edges_q <= (rst || frame_select_line_o) ? 8'h00
                 : edges_q + {7'h00, tick};
      if (rst || !spi_m || rx_empty || !frame_select_line_o
          || timeout_clear || tick)
         idle_q <= 6'h00;
      else if (idle_q != 6'h3F)
         idle_q <= idle_q + 6'h01;
   end
   sequence s_quiet;
      (spi_m && frame_select_line_o && $stable(clock_polarity_bit))[*3];
   endsequence
   chk_idle_level: assert property (s_quiet |->
      serial_bit_clock_o == clock_polarity_bit)
      else $error("serial clock off its idle level");
   chk_clock_framed: assert property (spi_m && $past(spi_m)
      && $past(spi_m, 2) && $changed(serial_bit_clock_o)
      |-> !frame_select_line_o)
      else $error("serial clock moved outside a frame");
   chk_frame_edges: assert property ($rose(frame_select_line_o)
      && spi_m |-> edges_q != 0
      && edges_q % (2 * (data_size_m1 + 1)) == 0)
      else $error("frame edge count wrong");
   chk_timeout_due: assert property (idle_q == 6'h28
      |-> raw_interrupt_status[2])
      else $error("receive timeout missing");
   chk_mask_view: assert property (masked_interrupt_status
      == (raw_interrupt_status & interrupt_mask_register))
      else $error("masked status wrong");
   chk_irq_join: assert property (irq == |masked_interrupt_status)
      else $error("combined request wrong");
   chk_overrun_sticky: assert property (raw_interrupt_status[3]
      && !overrun_clear |=> raw_interrupt_status[3])
      else $error("overrun flag lost");
   chk_dma_tx: assert property (dma_tx_req
      == (dma_control_register[1] && !tx_full))
      else $error("transmit DMA request wrong");
   chk_dma_rx: assert property (dma_rx_req
      == (dma_control_register[0] && !rx_empty))
      else $error("receive DMA request wrong");
   chk_rx_hold: assert property (!rx_rd && !$past(rx_rd)
      |=> $stable(rx_rdata))
      else $error("read data moved without a pop");
endmodule // sync_serial_port_props

// ### tb/ssp_slave_model.sv
// Off-chip SPI slave: returns a fixed reply, logs captured words.
// Assumes select frames each word when clock phase is zero.
`timescale 1ns/1ps
module ssp_slave_model
(
   input  wire        sclk,
   input  wire        ss_n,
   input  wire        mosi,
   input  wire        cpol,
   input  wire        cpha,
   input  wire [4:0]  len,
   input  wire [15:0] reply,
   output reg         miso
);
   logic [15:0] sh;
   logic [15:0] rx;
   int          n;
   logic [15:0] got[$];
   initial miso = 1'b0;
   always @(negedge ss_n)
   begin
      sh = reply << (16 - len);
      n = 0;
      if (!cpha)
         miso = sh[15];
   end
   // Released line must not show the last bit
   always @(posedge ss_n)
      miso = ~miso;
   always @(sclk)
      if (ss_n === 1'b0)
      begin
         if ((sclk != cpol) ^ cpha)
         begin
            rx = {rx[14:0], mosi};
            n = n + 1;
            if (n == len)
            begin
               got.push_back(rx & ~(16'hFFFF << len));
               n = 0;
               sh = reply << (16 - len);
            end
         end
         else if (cpha)
         begin
            miso = sh[15];
            sh = sh << 1;
         end
         else
         begin
            sh = sh << 1;
            miso = sh[15];
         end
      end
endmodule // ssp_slave_model

// ### tb/synchronous_serial_port_bench.sv
// Bench for sync_serial_port as SPI and pulse-format master against a slave model.
// Assumes 10 MHz clock; clock and select inputs loop back their own outputs.
`timescale 1ns/1ps
module synchronous_serial_port_bench;
   logic        clk_sys, rst, port_enable, slave_mode, tx_wr, rx_rd;
   logic        clock_polarity_bit, clock_phase_bit;
   logic        overrun_clear, timeout_clear, serial_receive_line;
   logic [1:0]  frame_format, dma_control_register;
   logic [3:0]  data_size_m1, interrupt_mask_register;
   logic [7:0]  prescale_divisor, clock_rate_field;
   logic [15:0] tx_wdata, reply, rx_rdata;
   logic [3:0]  raw_interrupt_status, masked_interrupt_status;
   logic        tx_full, rx_empty, irq, dma_tx_req, dma_rx_req;
   logic        serial_bit_clock_o, serial_bit_clock_oe;
   logic        frame_select_line_o, frame_select_line_oe;
   logic        serial_transmit_line, serial_transmit_oe;
   wire         serial_bit_clock_i = serial_bit_clock_o;
   wire         frame_select_line_i = frame_select_line_o;
   int          miscompares, n_checks, ng, c;
   // every setting keeps clk_sys at least twice the serial clock
   logic [7:0]  pt[4] = '{8'h04, 8'h0A, 8'hFE, 8'h06};
   logic [7:0]  rt[4] = '{8'h02, 8'h00, 8'h00, 8'h01};
   logic [3:0]  st[4] = '{4'h3, 4'hF, 4'h7, 4'hB};

   sync_serial_port uut (.*);
   ssp_slave_model slave (.sclk(serial_bit_clock_o),
      .ss_n(frame_select_line_o), .mosi(serial_transmit_line),
      .cpol(clock_polarity_bit), .cpha(clock_phase_bit),
      .len({1'b0, data_size_m1} + 5'h01), .reply(reply),
      .miso(serial_receive_line));

   initial
   begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   function automatic logic [15:0] low(input logic [15:0] w,
                                       input logic [3:0] d);
      return w & ~(16'hFFFF << ({1'b0, d} + 5'h01));
   endfunction

   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic put(input logic [15:0] w);
      @(posedge clk_sys);
      tx_wr <= 1'b1;
      tx_wdata <= w;
      @(posedge clk_sys);
      tx_wr <= 1'b0;
   endtask

   task automatic pop(input logic [15:0] exp);
      @(posedge clk_sys);
      rx_rd <= 1'b1;
      @(posedge clk_sys);
      rx_rd <= 1'b0;
      @(posedge clk_sys);
      #1 cmp(rx_rdata, exp);
   endtask

   // Cycles until the chosen pin next changes
   task automatic gap(input bit s, output int k);
      logic v;
      #1 k = 0;
      v = s ? frame_select_line_o : serial_bit_clock_o;
      while ((s ? frame_select_line_o : serial_bit_clock_o) === v
             && k < 4000)
      begin
         @(posedge clk_sys);
         #1 k++;
      end
   endtask

   // Select release and store push come at the tail tick, after the last capture
   task automatic xfer(input int n);
      int k;
      k = 0;
      while ((slave.got.size() < n || frame_select_line_o !== 1'b1)
             && k < 20000)
      begin
         @(posedge clk_sys);
         k++;
      end
      repeat (8) @(posedge clk_sys);
      #1 cmp(slave.got.size(), n);
   endtask

   task automatic setup(input logic [1:0] f, input int m);
      @(posedge clk_sys);
      port_enable <= 1'b0;
      frame_format <= f;
      clock_polarity_bit <= m[1];
      clock_phase_bit <= m[0];
      prescale_divisor <= pt[m];
      clock_rate_field <= rt[m];
      data_size_m1 <= st[m];
      reply <= 16'h5A3C + m;
      repeat (3) @(posedge clk_sys);
      port_enable <= 1'b1;
      repeat (4) @(posedge clk_sys);
   endtask

   task automatic t_modes;
      for (int m = 0; m < 4; m++)
      begin
         setup(2'h0, m);
         #1 cmp(serial_bit_clock_o, m[1]);
         put(16'hC3A5 ^ m);
         gap(1'b0, c);
         gap(1'b0, c);
         cmp(c, pt[m] * (rt[m] + 1) / 2);
         xfer(ng + 1);
         cmp(slave.got[ng], low(16'hC3A5 ^ m, st[m]));
         ng++;
         pop(low(16'h5A3C + m, st[m]));
      end
      $display("t_modes done");
   endtask

   task automatic t_burst;
      setup(2'h0, 0);
      port_enable <= 1'b0;
      dma_control_register <= 2'b11;
      @(posedge clk_sys);
      #1 cmp(irq, 1'b0);
      cmp(dma_tx_req, 1'b1);
      @(posedge clk_sys);
      interrupt_mask_register <= 4'h1;
      @(posedge clk_sys);
      #1 cmp(irq, 1'b1);
      for (int i = 0; i < 9; i++)
         put(16'h0010 + i);
      #1 cmp(tx_full, 1'b1);
      cmp(dma_tx_req, 1'b0);
      @(posedge clk_sys);
      port_enable <= 1'b1;
      xfer(ng + 8);
      for (int i = 0; i < 8; i++)
         cmp(slave.got[ng + i], low(16'h0010 + i, 4'h3));
      ng += 8;
      cmp(dma_rx_req, 1'b1);
      cmp(raw_interrupt_status[1], 1'b1);
      put(16'h0009);
      xfer(ng + 1);
      cmp(slave.got[ng], 16'h0009);
      ng++;
      cmp(raw_interrupt_status[3], 1'b1);
      repeat (40) @(posedge clk_sys);
      #1 cmp(raw_interrupt_status[2], 1'b1);
      @(posedge clk_sys);
      interrupt_mask_register <= 4'hC;
      @(posedge clk_sys);
      #1 cmp(masked_interrupt_status, 4'hC);
      for (int i = 0; i < 8; i++)
         pop(16'h000C);
      cmp(dma_rx_req, 1'b0);
      @(posedge clk_sys);
      overrun_clear <= 1'b1;
      timeout_clear <= 1'b1;
      @(posedge clk_sys);
      overrun_clear <= 1'b0;
      timeout_clear <= 1'b0;
      @(posedge clk_sys);
      #1 cmp(raw_interrupt_status[3:2], 2'h0);
      $display("t_burst done");
   endtask

   task automatic t_pulse;
      setup(2'h1, 0);
      #1 cmp({serial_bit_clock_o, frame_select_line_o,
              serial_transmit_oe}, 3'h0);
      put(16'h00C5);
      gap(1'b1, c);
      gap(1'b1, c);
      cmp(c, 12);
      c = 0;
      while (rx_empty !== 1'b0 && c < 4000)
      begin
         @(posedge clk_sys);
         c++;
      end
      repeat (8) @(posedge clk_sys);
      #1 cmp(rx_empty, 1'b0);
      cmp({serial_bit_clock_o, frame_select_line_o,
           serial_transmit_oe}, 3'h0);
      $display("t_pulse done");
   endtask

   task automatic summarize;
      $display("checks=%0d miscompares=%0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial
   begin
      {port_enable, slave_mode, tx_wr, rx_rd} = 4'h0;
      {overrun_clear, timeout_clear} = 2'h0;
      {clock_polarity_bit, clock_phase_bit} = 2'h0;
      {frame_format, dma_control_register} = 4'h0;
      {data_size_m1, interrupt_mask_register} = 8'h70;
      {prescale_divisor, clock_rate_field} = 16'h0400;
      {tx_wdata, reply} = 32'h0;
      {miscompares, n_checks, ng} = '0;
      rst = 1'b1;
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      t_modes;
      t_burst;
      t_pulse;
      summarize;
   end

   // Whole run is near 4k cycles; this bound is generous
   initial
   begin
      #5000000;
      miscompares++;
      summarize;
   end
endmodule // synchronous_serial_port_bench

bind sync_serial_port sync_serial_port_props props (.*);
